// ### hw/pbc_pkg.sv
// Purpose: shared constants for the paged bcd calendar clock
// Assumes: 8-bit registers, one per aligned 32-bit word on the bus
// Notes: byte address is four times the printed register index
package pbc_pkg;
  // ------------------------------------------------------------
  // register indices and byte addresses
  // ------------------------------------------------------------
  localparam logic [3:0] IDX_SEC = 4'h0;
  localparam logic [3:0] IDX_MIN = 4'h1;
  localparam logic [3:0] IDX_HOUR = 4'h2;
  localparam logic [3:0] IDX_WDAY = 4'h4;
  localparam logic [3:0] IDX_DAY = 4'h5;
  localparam logic [3:0] IDX_MON = 4'h6;
  localparam logic [3:0] IDX_YEAR = 4'h7;
  localparam logic [3:0] IDX_PAGE = 4'h8;
  localparam logic [3:0] IDX_RST = 4'hc;
  localparam int ADDR_LSB = 2;
  // ------------------------------------------------------------
  // control field positions
  // ------------------------------------------------------------
  localparam int PG_SEL = 0;
  localparam int PG_ALM_EN = 2;
  localparam int PG_CLK_EN = 3;
  localparam int PG_ADJ = 4;
  localparam int PG_INT_EN = 7;
  localparam int RS_ALM_CLR = 4;
  localparam int RS_SEC_CLR = 5;
  localparam int RS_DIS16 = 6;
  localparam int RS_DIS1 = 7;
  // ------------------------------------------------------------
  // bcd limits and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_30 = 8'h30;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_11 = 8'h11;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] BCD_01 = 8'h01;
  localparam logic [7:0] BCD_00 = 8'h00;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [2:0] WDAY_SAT = 3'h6;
  localparam logic [1:0] LEAP_NOW = 2'h0;
  localparam logic [5:0] PM_BIT = 6'h20;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] RST_RST = 8'hc0;
  // ------------------------------------------------------------
  // time base
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SEC_S = 1;
  localparam int SEC_CYC = CLK_HZ * SEC_S;
  localparam logic [1:0] RESP_OKAY = 2'h0;
endpackage

// ### hw/pbc_bcd_inc.sv
// Purpose: packed bcd increment with wrap to a floor value
// Assumes: input holds a legal bcd code no greater than the ceiling
// Notes: combinational, used for every calendar field except weekday
`timescale 1ns/10ps
module pbc_bcd_inc
  import pbc_pkg::*;
(
  input wire logic [7:0] val, // current bcd value
  input wire logic [7:0] top, // last legal value before wrap
  input wire logic [7:0] floor_val, // value after wrap
  output logic [7:0] nxt, // incremented value
  output logic wrap // high when val equals top
);
  wire [7:0] lo_inc = {val[7:4], val[3:0] + 4'h1};
  wire [7:0] hi_inc = {val[7:4] + 4'h1, 4'h0};
  assign wrap = (val == top);
  assign nxt = wrap ? floor_val : (val[3:0] == 4'h9) ? hi_inc : lo_inc;
endmodule // pbc_bcd_inc

// ### hw/pbc_clock.sv
// Purpose: paged bcd calendar clock with axi4-lite register access
// Assumes: single 10 MHz clock, one-second tick derived internally
// Notes: calendar state is not reset; only control bits are
// Operation
// [R01] clock and alarm pages share addresses, chosen by page select bit
// [R02] unused window addresses read zero and ignore writes
// [R03] reset clears only control bits; time and alarm values persist
// [R04] seconds are bcd 00 to 59 in bits 6..0, bit 7 zero
// [R05] minute exists on both pages, bcd 00 to 59, bit 7 zero
// [R06] 24-hour mode keeps hours 00 to 23, bits 7..6 zero
// [R07] 12-hour mode uses bit 5 as afternoon flag, hours 0 to 11
// [R08] weekday is three bits, sunday 000 to saturday 110
// [R09] day of month is bcd 01 to 31 on both pages
// [R10] software never loads a day missing from the month
// [R11] clock page month is bcd 01 to 12, bits 7..5 zero
// [R12] alarm page month address holds hour format bit 0
// [R13] year is two bcd digits wrapping 99 to 00
// [R14] every fourth year is leap, february gets 29 days
// [R15] clock page reads return the live counter value
// [R16] software reads twice and accepts matching pairs
// [R17] software loads time and calendar before enabling the clock
// [R18] alarm page holds minute, hour, weekday, day; seconds empty
// [R19] alarm page year address holds two-bit leap phase
// [R20] adjust request sampled on second tick, rounds to nearest minute
// [R21] alarm match pulses alarm output low and raises interrupt
// [R22] counters carry seconds to minutes up to year
// [R23] clock disabled means calendar holds and takes no carries
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
module pbc_clock
  import pbc_pkg::*;
#(
  parameter int TICK_CYC = SEC_CYC
) (
  input wire logic clk, // 10 MHz clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [31:0] s_awaddr, // write address
  input wire logic s_awvalid, // write address valid
  output logic s_awready, // write address ready
  input wire logic [31:0] s_wdata, // write data
  input wire logic [3:0] s_wstrb, // write byte strobes
  input wire logic s_wvalid, // write data valid
  output logic s_wready, // write data ready
  output logic [1:0] s_bresp, // write response
  output logic s_bvalid, // write response valid
  input wire logic s_bready, // write response ready
  input wire logic [31:0] s_araddr, // read address
  input wire logic s_arvalid, // read address valid
  output logic s_arready, // read address ready
  output logic [31:0] s_rdata, // read data
  output logic [1:0] s_rresp, // read response
  output logic s_rvalid, // read data valid
  input wire logic s_rready, // read data ready
  output logic alarm_n, // alarm pulse, active low
  output logic clock_interrupt // interrupt pulse, active high
);
  initial begin
    if (TICK_CYC < 2) $error("TICK_CYC too small");
  end
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] sec, min, hour, day;
  logic [2:0] wday;
  logic [4:0] mon;
  logic [7:0] year;
  logic [6:0] a_min;
  logic [5:0] a_hour, a_day;
  logic [2:0] a_wday;
  logic hour_format_select;
  logic [1:0] leap;
  logic [7:0] page_ctl, rst_ctl;
  logic [31:0] tick_cnt;
  logic tick;
  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  logic aw_hold, w_hold;
  logic [3:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane0;
  wire aw_take = s_awvalid && s_awready;
  wire w_take = s_wvalid && s_wready;
  wire do_wr = aw_hold && w_hold && !s_bvalid;
  wire ar_take = s_arvalid && s_arready;
  wire [3:0] ar_idx = s_araddr[ADDR_LSB+3:ADDR_LSB];
  wire ar_hi_zero = (s_araddr[31:ADDR_LSB+4] == '0);
  wire wr_ok = do_wr && w_lane0;
  wire pg1 = page_ctl[PG_SEL];
  function automatic logic wr_hit(input logic [3:0] idx, input logic [3:0] want);
    wr_hit = (idx == want);
  endfunction
  wire wr_sec = wr_ok && wr_hit(aw_idx, IDX_SEC) && !pg1; // R18
  wire wr_min = wr_ok && wr_hit(aw_idx, IDX_MIN);
  wire wr_hour = wr_ok && wr_hit(aw_idx, IDX_HOUR);
  wire wr_wday = wr_ok && wr_hit(aw_idx, IDX_WDAY);
  wire wr_day = wr_ok && wr_hit(aw_idx, IDX_DAY);
  wire wr_mon = wr_ok && wr_hit(aw_idx, IDX_MON);
  wire wr_year = wr_ok && wr_hit(aw_idx, IDX_YEAR);
  wire wr_page = wr_ok && wr_hit(aw_idx, IDX_PAGE);
  wire wr_rst = wr_ok && wr_hit(aw_idx, IDX_RST);
  // ------------------------------------------------------------
  // calendar increment chain
  // ------------------------------------------------------------
  wire clk_en = page_ctl[PG_CLK_EN];
  wire step = tick && clk_en; // R23
  wire adj_carry = page_ctl[PG_ADJ] && (sec >= BCD_30); // R20
  wire [7:0] sec_n, min_n, day_n, mon_n, year_n, h24_n, h12_n;
  wire sec_w, min_w, day_w, mon_w, year_w, h24_w, h12_w;
  wire [7:0] day_top;
  wire [7:0] mon8 = {3'h0, mon};
  wire [7:0] h12_lo = {3'h0, hour[4:0]};
  pbc_bcd_inc u_sec (.val(sec), .top(BCD_59), .floor_val(BCD_00), .nxt(sec_n), .wrap(sec_w));
  pbc_bcd_inc u_min (.val(min), .top(BCD_59), .floor_val(BCD_00), .nxt(min_n), .wrap(min_w));
  pbc_bcd_inc u_h24 (.val(hour), .top(BCD_23), .floor_val(BCD_00), .nxt(h24_n), .wrap(h24_w));
  pbc_bcd_inc u_h12 (.val(h12_lo), .top(BCD_11), .floor_val(BCD_00), .nxt(h12_n),
    .wrap(h12_w));
  pbc_bcd_inc u_day (.val(day), .top(day_top), .floor_val(BCD_01), .nxt(day_n), .wrap(day_w));
  pbc_bcd_inc u_mon (.val(mon8), .top(BCD_12), .floor_val(BCD_01), .nxt(mon_n), .wrap(mon_w));
  pbc_bcd_inc u_year (.val(year), .top(BCD_99), .floor_val(BCD_00), .nxt(year_n),
    .wrap(year_w));
  // month length from month and leap phase
  wire is_31 = (mon8 == 8'h01) || (mon8 == 8'h03) || (mon8 == 8'h05) || (mon8 == 8'h07)
    || (mon8 == 8'h08) || (mon8 == 8'h10) || (mon8 == BCD_12);
  wire [7:0] feb_top = (leap == LEAP_NOW) ? 8'h29 : 8'h28; // R14
  assign day_top = (mon8 == MON_FEB) ? feb_top : is_31 ? 8'h31 : 8'h30; // R22
  // carry enables
  wire sec_roll = step && (sec_w || adj_carry); // R20
  wire hr_c = sec_roll && min_w;
  wire hr_w = hour_format_select ? h24_w : (h12_w && hour[5]);
  wire day_c = hr_c && hr_w;
  wire mon_c = day_c && day_w;
  wire year_c = mon_c && mon_w;
  wire [7:0] hour_next = hour_format_select ? h24_n :
    {2'h0, (h12_w ? ~hour[5] : hour[5]), h12_n[4:0]}; // R07
  // ------------------------------------------------------------
  // tick and counters
  // ------------------------------------------------------------
  assign tick = (tick_cnt == 32'(TICK_CYC - 1));
  always_ff @(posedge clk) begin
    if (!rst_b || rst_ctl[RS_SEC_CLR] || tick) tick_cnt <= '0;
    else tick_cnt <= tick_cnt + 32'h1;
  end
  // no reset on time registers: contents survive system reset
  always_ff @(posedge clk) begin // R03
    if (wr_sec) sec <= {1'b0, w_byte[6:0]}; // R04
    else if (rst_ctl[RS_SEC_CLR] || (step && page_ctl[PG_ADJ])) sec <= BCD_00; // R20
    else if (step) sec <= sec_n; // R22
    if (wr_min && !pg1) min <= {1'b0, w_byte[6:0]}; // R05
    else if (sec_roll) min <= min_n;
    if (wr_hour && !pg1) hour <= {2'h0, w_byte[5:0]}; // R06
    else if (hr_c) hour <= hour_next;
    if (wr_wday && !pg1) wday <= w_byte[2:0]; // R08
    else if (day_c) wday <= (wday == WDAY_SAT) ? 3'h0 : wday + 3'h1;
    if (wr_day && !pg1) day <= {2'h0, w_byte[5:0]}; // R09
    else if (day_c) day <= day_n;
    if (wr_mon && !pg1) mon <= w_byte[4:0]; // R11
    else if (mon_c) mon <= mon_n[4:0];
    if (wr_year && !pg1) year <= w_byte; // R13
    else if (year_c) year <= year_n;
    if (wr_year && pg1) leap <= w_byte[1:0]; // R19
    else if (year_c) leap <= leap + 2'h1; // R14
    if (wr_mon && pg1) hour_format_select <= w_byte[0]; // R12
  end
  always_ff @(posedge clk) begin // R18
    if (rst_b && rst_ctl[RS_ALM_CLR]) begin
      a_min <= 7'h0;
      a_hour <= 6'h0;
      a_day <= 6'h01;
      a_wday <= 3'h0;
    end else begin
      if (wr_min && pg1) a_min <= w_byte[6:0];
      if (wr_hour && pg1) a_hour <= w_byte[5:0];
      if (wr_day && pg1) a_day <= w_byte[5:0];
      if (wr_wday && pg1) a_wday <= w_byte[2:0];
    end
  end
  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      page_ctl <= PAGE_RST; // R03
      rst_ctl <= RST_RST;
    end else begin
      if (wr_page) page_ctl <= {w_byte[7], 2'h0, w_byte[4] | page_ctl[PG_ADJ],
        w_byte[3:2], 1'b0, w_byte[0]};
      else if (step) page_ctl[PG_ADJ] <= 1'b0; // R20
      if (wr_rst) rst_ctl <= {w_byte[7:4], 4'h0};
      else begin
        rst_ctl[RS_SEC_CLR] <= 1'b0;
        rst_ctl[RS_ALM_CLR] <= 1'b0;
      end
    end
  end
  // ------------------------------------------------------------
  // alarm match
  // ------------------------------------------------------------
  wire match = (min[6:0] == a_min) && (hour[5:0] == a_hour) && (day[5:0] == a_day)
    && (wday == a_wday);
  wire alm_hit = page_ctl[PG_ALM_EN] && step && match && (sec == BCD_00);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      alarm_n <= 1'b1;
      clock_interrupt <= 1'b0;
    end else begin
      alarm_n <= !alm_hit; // R21
      clock_interrupt <= alm_hit && page_ctl[PG_INT_EN]; // R21
    end
  end
  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00; // R02
    if (ar_hi_zero) begin
      unique case (ar_idx)
        IDX_SEC: rd_byte = pg1 ? 8'h00 : {1'b0, sec[6:0]}; // R15
        IDX_MIN: rd_byte = pg1 ? {1'b0, a_min} : {1'b0, min[6:0]}; // R01
        IDX_HOUR: rd_byte = pg1 ? {2'h0, a_hour} : {2'h0, hour[5:0]};
        IDX_WDAY: rd_byte = pg1 ? {5'h0, a_wday} : {5'h0, wday};
        IDX_DAY: rd_byte = pg1 ? {2'h0, a_day} : {2'h0, day[5:0]};
        IDX_MON: rd_byte = pg1 ? {7'h0, hour_format_select} : {3'h0, mon};
        IDX_YEAR: rd_byte = pg1 ? {6'h0, leap} : year;
        IDX_PAGE: rd_byte = page_ctl;
        IDX_RST: rd_byte = rst_ctl;
        default: rd_byte = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_idx <= 4'h0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_bvalid <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
    end else begin
      if (aw_take) begin
        aw_hold <= 1'b1;
        aw_idx <= (s_awaddr[31:ADDR_LSB+4] == '0) ? s_awaddr[ADDR_LSB+3:ADDR_LSB] : 4'hf;
      end else if (do_wr) aw_hold <= 1'b0;
      if (w_take) begin
        w_hold <= 1'b1;
        w_byte <= s_wdata[7:0];
        w_lane0 <= s_wstrb[0];
      end else if (do_wr) w_hold <= 1'b0;
      if (do_wr) s_bvalid <= 1'b1;
      else if (s_bready) s_bvalid <= 1'b0;
      if (ar_take) begin
        s_rvalid <= 1'b1;
        s_rdata <= {24'h0, rd_byte};
      end else if (s_rready) s_rvalid <= 1'b0;
    end
  end
  assign s_awready = !aw_hold && !s_bvalid && rst_b;
  assign s_wready = !w_hold && !s_bvalid && rst_b;
  assign s_arready = !s_rvalid && rst_b;
  assign s_bresp = RESP_OKAY;
  assign s_rresp = RESP_OKAY;
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_sec_range;
    @(posedge clk) disable iff (!rst_b) (sec <= BCD_59) |=> (sec <= BCD_59);
  endproperty
  a_sec_range: assert property (p_sec_range) else $error("seconds left range"); // R04
  property p_hold;
    // case equality: calendar is unset after power-up and must not trip this
    @(posedge clk) disable iff (!rst_b) (!clk_en && !wr_ok) |=>
      (min === $past(min)) && (day === $past(day));
  endproperty
  a_hold: assert property (p_hold) else $error("calendar moved while disabled"); // R23
  property p_unused;
    @(posedge clk) disable iff (!rst_b) ar_take && ar_hi_zero && (ar_idx == 4'h3) |=>
      s_rvalid && (s_rdata == 32'h0);
  endproperty
  a_unused: assert property (p_unused) else $error("unused address not zero"); // R02
  property p_carry;
    @(posedge clk) disable iff (!rst_b) step && (sec == BCD_59) && !page_ctl[PG_ADJ] && !wr_ok
      |=> (sec == BCD_00) && (min != $past(min));
  endproperty
  a_carry: assert property (p_carry) else $error("no minute carry"); // R22
  property p_adj;
    @(posedge clk) disable iff (!rst_b) step && page_ctl[PG_ADJ] && (sec < BCD_30) && !wr_ok
      |=> (sec == BCD_00) && $stable(min) && !page_ctl[PG_ADJ];
  endproperty
  a_adj: assert property (p_adj) else $error("adjust low half wrong"); // R20
  property p_alarm;
    @(posedge clk) disable iff (!rst_b) alm_hit |=> !alarm_n ##1 alarm_n;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm pulse wrong"); // R21
  property p_pagesel;
    @(posedge clk) disable iff (!rst_b) ar_take && pg1 && (ar_idx == IDX_SEC) && ar_hi_zero
      |=> s_rdata == 32'h0;
  endproperty
  a_pagesel: assert property (p_pagesel) else $error("alarm page seconds not empty"); // R01
  property p_year;
    @(posedge clk) disable iff (!rst_b) year_c && (year == BCD_99) && !wr_ok |=> year == BCD_00;
  endproperty
  a_year: assert property (p_year) else $error("year wrap wrong"); // R13
  c_alarm: cover property (@(posedge clk) alm_hit);
  c_year: cover property (@(posedge clk) year_c);
  c_adj: cover property (@(posedge clk) step && adj_carry);
endmodule // pbc_clock

// ### test/test_pbc_clock.sv
// Purpose: self-checking bench for the paged bcd calendar clock
// Assumes: short tick of 20 cycles, axi4-lite master driven on the rising edge
// Notes: ready and valid are sampled on the falling edge, where they have settled
`timescale 1ns/10ps
module test_pbc_clock
  import pbc_pkg::*;
;
  localparam int TICK = 20;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] s_awaddr = 32'h0, s_wdata = 32'h0, s_araddr = 32'h0, s_rdata;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, alarm_n, clock_interrupt;
  logic [1:0] s_bresp, s_rresp;
  int mismatches = 0;
  int n_compared = 0;
  always #50 clk = ~clk;
  pbc_clock #(.TICK_CYC(TICK)) dut_u (.clk(clk), .rst_b(rst_b), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .alarm_n(alarm_n), .clock_interrupt(clock_interrupt));
  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic conclude();
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ba, input logic [7:0] v);
    logic a, w, b;
    @(posedge clk);
    s_awaddr <= {24'h0, ba};
    s_wdata <= {24'h0, v};
    s_wstrb <= 4'h1;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      a = s_awvalid && s_awready;
      w = s_wvalid && s_wready;
      b = s_bvalid === 1'b1;
      @(posedge clk);
      if (a) s_awvalid <= 1'b0;
      if (w) s_wvalid <= 1'b0;
      if (b) s_bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] ba, output logic [31:0] v);
    logic a, r;
    @(posedge clk);
    s_araddr <= {24'h0, ba};
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      a = s_arvalid && s_arready;
      r = s_rvalid === 1'b1;
      v = s_rdata;
      @(posedge clk);
      if (a) s_arvalid <= 1'b0;
      if (r) s_rready <= 1'b0;
    end
  endtask
  task automatic rc(input logic [7:0] ba, input logic [7:0] exp);
    logic [31:0] v;
    rd(ba, v);
    chk(v, {24'h0, exp});
  endtask
  // clock held off while loading; page 1 carries format and leap phase
  task automatic load(input logic [7:0] s, m, h, w, d, mo, y, input logic [1:0] lp,
                      input logic f);
    wr(8'h20, 8'h01);
    wr(8'h18, {7'h0, f});
    wr(8'h1c, {6'h0, lp});
    wr(8'h20, 8'h00);
    wr(8'h00, s);
    wr(8'h04, m);
    wr(8'h08, h);
    wr(8'h10, w);
    wr(8'h14, d);
    wr(8'h18, mo);
    wr(8'h1c, y);
  endtask
  // enable with the given control byte, then poll until the seconds move once
  task automatic go(input logic [7:0] ctl, input logic [7:0] old);
    logic [31:0] v;
    wr(8'h20, ctl);
    for (int i = 0; i < 200; i++) begin
      rd(8'h00, v);
      if (v[7:0] !== old) break;
    end
    wr(8'h20, 8'h00);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rc(8'h20, PAGE_RST);
    rc(8'h30, RST_RST);
    wr(8'h0c, 8'hff);
    rc(8'h0c, 8'h00);
    wr(8'h24, 8'hff);
    rc(8'h24, 8'h00);
    wr(8'h2c, 8'hff);
    rc(8'h2c, 8'h00);
    load(8'h59, 8'h59, 8'h23, 8'h06, 8'h31, 8'h12, 8'h99, 2'h3, 1'b1);
    repeat (3 * TICK) @(posedge clk);
    rc(8'h00, 8'h59);
    rc(8'h1c, 8'h99);
    go(8'h08, 8'h59);
    rc(8'h00, 8'h00);
    rc(8'h04, 8'h00);
    rc(8'h08, 8'h00);
    rc(8'h10, 8'h00);
    rc(8'h14, 8'h01);
    rc(8'h18, 8'h01);
    rc(8'h1c, 8'h00);
    begin
      logic [31:0] p, q;
      rd(8'h14, p);
      rd(8'h14, q);
      chk(q, p);
      chk(q, 32'h01);
    end
    wr(8'h20, 8'h01);
    rc(8'h1c, 8'h00);
    rc(8'h18, 8'h01);
    rc(8'h00, 8'h00);
    load(8'h59, 8'h59, 8'h23, 8'h00, 8'h28, 8'h02, 8'h00, 2'h0, 1'b1);
    go(8'h08, 8'h59);
    rc(8'h14, 8'h29);
    load(8'h59, 8'h59, 8'h23, 8'h00, 8'h28, 8'h02, 8'h01, 2'h1, 1'b1);
    go(8'h08, 8'h59);
    rc(8'h14, 8'h01);
    rc(8'h18, 8'h03);
    load(8'h59, 8'h59, 8'h31, 8'h00, 8'h10, 8'h01, 8'h05, 2'h1, 1'b0);
    rc(8'h08, 8'h31);
    go(8'h08, 8'h59);
    rc(8'h08, 8'h00);
    rc(8'h14, 8'h11);
    rc(8'h10, 8'h01);
    load(8'h45, 8'h10, 8'h05, 8'h01, 8'h05, 8'h01, 8'h05, 2'h1, 1'b1);
    go(8'h18, 8'h45);
    rc(8'h00, 8'h00);
    rc(8'h04, 8'h11);
    load(8'h15, 8'h10, 8'h05, 8'h01, 8'h05, 8'h01, 8'h05, 2'h1, 1'b1);
    go(8'h18, 8'h15);
    rc(8'h04, 8'h10);
    rc(8'h20, 8'h00);
    wr(8'h20, 8'h01);
    wr(8'h30, 8'hd0);
    rc(8'h04, 8'h00);
    rc(8'h08, 8'h00);
    rc(8'h10, 8'h00);
    rc(8'h14, 8'h01);
    wr(8'h04, 8'h05);
    wr(8'h08, 8'h10);
    wr(8'h10, 8'h01);
    wr(8'h14, 8'h05);
    load(8'h59, 8'h04, 8'h10, 8'h01, 8'h05, 8'h01, 8'h05, 2'h1, 1'b1);
    rc(8'h04, 8'h04);
    wr(8'h20, 8'h01);
    rc(8'h04, 8'h05);
    wr(8'h20, 8'h8c);
    for (int i = 0; i < 100; i++) begin
      @(negedge clk);
      if (alarm_n === 1'b0) break;
    end
    chk(alarm_n, 1'b0);
    chk(clock_interrupt, 1'b1);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rc(8'h20, PAGE_RST);
    rc(8'h30, RST_RST);
    rc(8'h04, 8'h05);
    conclude();
  end
endmodule // test_pbc_clock
